/* io_address_decoder.sv */
// Address decoder that claims the relocatable 2 MB I/O window and selects units.
`timescale 1ns/1ps

// How it works
// - Every access inside the 2 MB window at the chosen base is claimed.
// - The base is picked once after reset from four possible locations.
// - Unassigned offsets inside the window are still acknowledged.
// - Strap bits are captured on the third clock edge after reset releases and held until next reset.
// - Codes 00, 01, 10, 11 place the base at F0000000, F0400000, FF800000, FFC00000.
// - First 1 MB goes to the external bus; units get 4 KB regions; rest unassigned.
// - Misc region decodes power, error log, version, I/O reset, arbitration mask.
// - Clock region decodes four word registers at offsets 000 to 00C.
// - Serial offsets 0 and 1 pick divisor latch bytes when the access bit is set.
// - Floppy region decodes reset, command data, status and buffer registers.
// - Clock registers accept only full-word accesses at region-relative offsets.
module io_address_decoder
	import io_decode_pkg::*;
(
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     resetn,
	// Strap pins: external 8-bit bus bits 1 and 0
	input  wire logic [1:0] strapPins,
	// System bus request
	input  wire bus_req_s   busReq,
	// Divisor latch access bits of the three serial register sets
	input  wire logic [2:0] divisorLatchAccess,
	// Decode results
	output claim_s          claim,
	output logic [1:0]      spaceCode,
	output logic            spaceValid
);

	// ==========================================================================
	// Decode helpers
	function automatic logic [31:0] windowBase(input logic [1:0] code);
		unique case (code)
			2'h0: windowBase = BASE_CODE00;
			2'h1: windowBase = BASE_CODE01;
			2'h2: windowBase = BASE_CODE10;
			default: windowBase = BASE_CODE11;
		endcase
	endfunction

	function automatic unit_e unitOf(input logic [OFFSET_W-1:0] off);
		unit_e u;
		u = UNIT_UNASSGN;
		if (!off[20]) begin
			u = UNIT_EXTBUS;
		end else if (off[19:12] < UNIT_FIRST_FREE) begin
			u = unit_e'(15'h0002 << off[15:12]);
		end
		return u;
	endfunction

	// Byte 0 and 1 of a serial set change meaning with the divisor latch bit.
	function automatic logic [3:0] serialSel(input logic [19:0] off,
	                                         input logic [19:0] base,
	                                         input logic        divisor_latch_access);
		logic [3:0] s;
		s = 4'h0;
		if (off == base) begin
			s = divisor_latch_access ? 4'h1 : 4'h4;
		end else if (off == base + 20'h1) begin
			s = divisor_latch_access ? 4'h2 : 4'h8;
		end
		return s;
	endfunction

	function automatic logic match(input logic [11:0] a, input logic [11:0] b);
		return a == b;
	endfunction

	// ==========================================================================
	// Register selects inside single regions
	// Each select is one bit per register word; any other offset in the region
	// selects nothing, so the unit sees an acknowledged access with no target.
	function automatic logic [4:0] miscSel(input logic [11:0] off);
		logic [4:0] s;
		s[0] = match(off, MISC_POWER);
		s[1] = match(off, MISC_ERRLOG);
		s[2] = match(off, MISC_VERSION);
		s[3] = match(off, MISC_IORESET);
		s[4] = match(off, MISC_ARBMASK);
		return s;
	endfunction

	// Only word offsets match; byte lanes of a word are not told apart here.
	function automatic logic [3:0] clkSel(input logic [11:0] off);
		logic [3:0] s;
		s[0] = match(off, CLK_CTL40);
		s[1] = match(off, CLK_CTL20);
		s[2] = match(off, CLK_AUD0);
		s[3] = match(off, CLK_AUD1);
		return s;
	endfunction

	// The gap between main status and the buffer words selects nothing.
	function automatic logic [5:0] floppySel(input logic [11:0] off);
		logic [5:0] s;
		s[0] = match(off, FLOP_RESET);
		s[1] = match(off, FLOP_CMDDATA);
		s[2] = match(off, FLOP_MAINSTAT);
		s[3] = match(off, FLOP_BUFDATA);
		s[4] = match(off, FLOP_BUFCTL);
		s[5] = match(off, FLOP_BUFSTAT);
		return s;
	endfunction

	// ==========================================================================
	// State
	decode_state_s state_reg;
	decode_state_s state_next;

	logic [OFFSET_W-1:0] reqOffset;
	logic                inWindow;
	unit_e               reqUnit;
	logic [11:0]         regOff;
	logic [31:0]         baseNow;

	// ==========================================================================
	// Window compare
	// The base only moves at reset, so the compare is a plain equality on the
	// upper address bits; the window is aligned to its own 2 MB size.
	assign baseNow   = windowBase(state_reg.space);
	assign reqOffset = busReq.addr[OFFSET_W-1:0];
	assign inWindow  = busReq.addr[31:OFFSET_W] == baseNow[31:OFFSET_W];
	assign reqUnit   = unitOf(reqOffset);
	assign regOff    = reqOffset[11:0];

	// ==========================================================================
	// Next state
	// All decoding lands in flops, so every claim output is one cycle behind
	// the request; this costs a cycle of latency but keeps outputs glitch free.
	always_comb begin
		state_next = state_reg;

		// Straps pass two flops before capture, since they come straight off pins.
		state_next.strapMeta = strapPins;
		state_next.strapSync = state_reg.strapMeta;
		if (!state_reg.spaceValid) begin
			// Capture happens once, in the cycles right after reset release.
			// The synchroniser must fill before its output means anything.
			if (state_reg.settle == STRAP_SETTLE) begin
				state_next.spaceValid = 1'b1;
				state_next.space      = state_reg.strapSync;
			end else begin
				state_next.settle = state_reg.settle + 2'h1;
			end
		end

		state_next.claim = '0;
		if (busReq.valid && state_reg.spaceValid && inWindow) begin
			// Unassigned offsets are acknowledged with no unit selected.
			state_next.claim.ack    = 1'b1;
			state_next.claim.write  = busReq.write;
			state_next.claim.offset = reqOffset;
			state_next.claim.unit   = (reqUnit == UNIT_UNASSGN) ? UNIT_NONE : reqUnit;
			unique case (reqUnit)
				UNIT_MISC: begin
					state_next.claim.regSel.misc = miscSel(regOff);
				end
				UNIT_CLKCFG: begin
					// Part-word accesses select nothing; the region still acks.
					if (busReq.fullWord) begin
						state_next.claim.regSel.clkCfg = clkSel(regOff);
					end
				end
				UNIT_FLOPPY: begin
					state_next.claim.regSel.floppy = floppySel(regOff);
				end
				UNIT_AUDIO: begin
					state_next.claim.regSel.serial[0] =
						serialSel(reqOffset[19:0], SER0_BASE, divisorLatchAccess[0]);
					state_next.claim.regSel.serial[1] =
						serialSel(reqOffset[19:0], SER1_BASE, divisorLatchAccess[1]);
				end
				UNIT_RS232: begin
					state_next.claim.regSel.serial[2] =
						serialSel(reqOffset[19:0], SER2_BASE, divisorLatchAccess[2]);
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================================
	// Registers
	// Reset clears the latched code too; a new reset always re-reads the straps.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg       <= '0;
			state_reg.space <= SPACE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================================
	// Outputs
	assign claim      = state_reg.claim;
	assign spaceCode  = state_reg.space;
	assign spaceValid = state_reg.spaceValid;

endmodule

/* io_decode_pkg.sv */
// Constants and carrier types for the I/O window address decoder.
package io_decode_pkg;

	// ==========================================================================
	// Window placement
	localparam int          OFFSET_W     = 21;
	localparam logic [31:0] BASE_CODE00  = 32'hf000_0000;
	localparam logic [31:0] BASE_CODE01  = 32'hf040_0000;
	localparam logic [31:0] BASE_CODE10  = 32'hff80_0000;
	localparam logic [31:0] BASE_CODE11  = 32'hffc0_0000;
	localparam logic [1:0]  SPACE_RESET  = 2'h0;
	// Edges after reset release before the strap synchroniser output is trusted.
	localparam logic [1:0]  STRAP_SETTLE = 2'h2;

	// ==========================================================================
	// Region map inside the window
	localparam logic [7:0]  UNIT_FIRST_FREE = 8'h0d;
	localparam logic [11:0] MISC_POWER      = 12'h000;
	localparam logic [11:0] MISC_ERRLOG     = 12'h004;
	localparam logic [11:0] MISC_VERSION    = 12'h008;
	localparam logic [11:0] MISC_IORESET    = 12'h00c;
	localparam logic [11:0] MISC_ARBMASK    = 12'h010;
	localparam logic [11:0] CLK_CTL40       = 12'h000;
	localparam logic [11:0] CLK_CTL20       = 12'h004;
	localparam logic [11:0] CLK_AUD0        = 12'h008;
	localparam logic [11:0] CLK_AUD1        = 12'h00c;
	localparam logic [11:0] FLOP_RESET      = 12'h000;
	localparam logic [11:0] FLOP_CMDDATA    = 12'h004;
	localparam logic [11:0] FLOP_MAINSTAT   = 12'h008;
	localparam logic [11:0] FLOP_BUFDATA    = 12'h014;
	localparam logic [11:0] FLOP_BUFCTL     = 12'h018;
	localparam logic [11:0] FLOP_BUFSTAT    = 12'h01c;
	localparam logic [19:0] SER0_BASE       = 20'h0_4040;
	localparam logic [19:0] SER1_BASE       = 20'h0_4060;
	localparam logic [19:0] SER2_BASE       = 20'h0_5800;

	// One-hot unit selects; bit order follows the 4 KB region order.
	typedef enum logic [14:0] {
		UNIT_NONE    = 15'h0000,
		UNIT_EXTBUS  = 15'h0001,
		UNIT_INTR    = 15'h0002,
		UNIT_PPDMA   = 15'h0004,
		UNIT_PAR     = 15'h0008,
		UNIT_PPDRST  = 15'h0010,
		UNIT_AUDIO   = 15'h0020,
		UNIT_RS232   = 15'h0040,
		UNIT_SCSI    = 15'h0080,
		UNIT_LAN     = 15'h0100,
		UNIT_KBD     = 15'h0200,
		UNIT_RTC     = 15'h0400,
		UNIT_FLOPPY  = 15'h0800,
		UNIT_CLKCFG  = 15'h1000,
		UNIT_MISC    = 15'h2000,
		UNIT_UNASSGN = 15'h4000
	} unit_e;

	// ==========================================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        fullWord;
		logic [31:0] addr;
	} bus_req_s;

	// Serial register select order: divisor low, divisor high, data, interrupt enable.
	typedef struct packed {
		logic [2:0][3:0] serial;
		logic [5:0]      floppy;
		logic [3:0]      clkCfg;
		logic [4:0]      misc;
	} reg_sel_s;

	typedef struct packed {
		logic                ack;
		logic                write;
		unit_e               unit;
		logic [OFFSET_W-1:0] offset;
		reg_sel_s            regSel;
	} claim_s;

	typedef struct packed {
		logic [1:0] strapMeta;
		logic [1:0] strapSync;
		logic [1:0] settle;
		logic       spaceValid;
		logic [1:0] space;
		claim_s     claim;
	} decode_state_s;

endpackage

/* io_decode_properties.sv */
// Concurrent checks on the ports of the I/O window address decoder.
`timescale 1ns/1ps
module io_decode_properties
	import io_decode_pkg::*;
(
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic [1:0] strapPins,
	input wire bus_req_s   busReq,
	input wire logic [2:0] divisorLatchAccess,
	input wire claim_s     claim,
	input wire logic [1:0] spaceCode,
	input wire logic       spaceValid
);
	// ====
	// Window hit worked out from the latched code.
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic [31:0] winBase;
	logic        hit;
	assign winBase = spaceCode[1] ? (spaceCode[0] ? BASE_CODE11 : BASE_CODE10)
		: (spaceCode[0] ? BASE_CODE01 : BASE_CODE00);
	assign hit = busReq.valid && spaceValid && busReq.addr[31:21] == winBase[31:21];
	a_window_ack: assert property (hit |=> claim.ack) else $error("no ack");
	a_outside_quiet: assert property (!hit |=> !claim.ack) else $error("stray ack");
	a_strap_capture: assert property ($rose(spaceValid) |-> spaceCode == $past(strapPins, 3))
		else $error("strap code");
	a_space_hold: assert property (spaceValid |=> $stable(spaceCode)) else $error("code moved");
	a_unit_onehot: assert property ($onehot0(claim.unit)) else $error("two units");
	a_unit_region: assert property (claim.ack && claim.offset[20]
		&& claim.offset[19:12] < UNIT_FIRST_FREE |-> claim.unit == 15'h0002 << claim.offset[15:12])
		else $error("unit region");
	a_unassigned_ack: assert property (claim.ack && claim.offset[20]
		&& claim.offset[19:12] >= UNIT_FIRST_FREE |-> claim.unit == UNIT_NONE && claim.regSel == '0)
		else $error("unassigned");
	a_clk_word: assert property (claim.regSel.clkCfg != 4'h0 |-> $past(busReq.fullWord))
		else $error("clock width");
	a_serial_divisor_latch_access: assert property (claim.regSel.serial[2][1] |-> $past(divisorLatchAccess[2]))
		else $error("divisor sel");
endmodule

bind io_address_decoder io_decode_properties u_props (.clk(clk), .resetn(resetn),
	.strapPins(strapPins), .busReq(busReq), .divisorLatchAccess(divisorLatchAccess),
	.claim(claim), .spaceCode(spaceCode), .spaceValid(spaceValid));

/* bus_master_model.sv */
// Processor-side bus master issuing one-cycle read or write requests.
`timescale 1ns/1ps
module bus_master_model
	import io_decode_pkg::*;
(
	input  wire logic clk,
	output bus_req_s  busReq
);
	initial busReq = '0;
	task automatic access(input logic [31:0] a, input logic fw, input logic w);
		@(negedge clk);
		busReq = '{1'b1, w, fw, a};
		@(negedge clk);
		// Released address lines show the inverse so a stale address is never reused.
		busReq = '{1'b0, 1'b0, 1'b0, ~a};
	endtask
endmodule

/* tb.sv */
// Self-checking bench for the I/O window address decoder.
`timescale 1ns/1ps
module tb
	import io_decode_pkg::*;
;
	// ====
	// Stimulus tables: one access per row.
	localparam int N = 13;
	localparam logic [31:0] BASES [4] = '{BASE_CODE00, BASE_CODE01, BASE_CODE10, BASE_CODE11};
	localparam logic [20:0] OFFS [N] = '{21'h10c000, 21'h10c010, 21'h10b000, 21'h10b00c,
		21'h10b004, 21'h10a000, 21'h10a01c, 21'h105801, 21'h105801, 21'h104060, 21'h000010,
		21'h10d000, 21'h1ffffc};
	localparam unit_e UNITS [N] = '{UNIT_MISC, UNIT_MISC, UNIT_CLKCFG, UNIT_CLKCFG, UNIT_CLKCFG,
		UNIT_FLOPPY, UNIT_FLOPPY, UNIT_RS232, UNIT_RS232, UNIT_AUDIO, UNIT_EXTBUS, UNIT_NONE,
		UNIT_NONE};
	localparam int SELB [N] = '{0, 4, 5, 8, -1, 9, 14, 24, 26, 19, -1, -1, -1};
	localparam logic [N-1:0] FW = 13'h1fef;
	localparam logic [N-1:0] DL = 13'h0280;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic [1:0] strapPins = 2'h0;
	logic [2:0] divisorLatchAccess = 3'h0;
	bus_req_s   busReq;
	claim_s     claim;
	logic [1:0] spaceCode;
	logic       spaceValid;
	int         n_errors = 0;
	int         num_checks = 0;
	always #5 clk = ~clk;
	bus_master_model u_host (.clk(clk), .busReq(busReq));
	io_address_decoder u_dut (.clk(clk), .resetn(resetn), .strapPins(strapPins),
		.busReq(busReq), .divisorLatchAccess(divisorLatchAccess), .claim(claim),
		.spaceCode(spaceCode), .spaceValid(spaceValid));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic reset_with(input logic [1:0] code);
		@(negedge clk);
		resetn = 1'b0;
		strapPins = code;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		for (int i = 0; i < 10 && spaceValid !== 1'b1; i++) @(negedge clk);
		if (spaceValid !== 1'b1) begin
			n_errors++;
			results();
		end
	endtask
	task automatic scen_bases();
		for (int c = 0; c < 4; c++) begin
			reset_with(2'(c));
			chk("spaceCode", 32'(spaceCode), 32'(c));
			chk("spaceValid", 32'(spaceValid), 32'h1);
			u_host.access(BASES[c] | 32'h0010_c004, 1'b1, 1'b0);
			chk("errlog", {claim.ack, 26'h0, claim.regSel.misc}, 32'h8000_0002);
			u_host.access(BASES[c] + 32'h0020_0000, 1'b1, 1'b0);
			chk("above", 32'(claim.ack), 32'h0);
			u_host.access(BASES[c] - 32'h4, 1'b1, 1'b0);
			chk("below", 32'(claim.ack), 32'h0);
			u_host.access(32'hfffb_b000, 1'b1, 1'b0);
			chk("bootpage", 32'(claim.ack), 32'h0);
		end
	endtask
	task automatic scen_map();
		reset_with(2'h0);
		for (int i = 0; i < N; i++) begin
			divisorLatchAccess = {3{DL[i]}};
			u_host.access(BASE_CODE00 | 32'(OFFS[i]), FW[i], 1'(i));
			chk("ack", 32'(claim.ack), 32'h1);
			chk("write", 32'(claim.write), 32'(i % 2));
			chk("offset", 32'(claim.offset), 32'(OFFS[i]));
			chk("unit", 32'(claim.unit), 32'(UNITS[i]));
			chk("regSel", 32'(claim.regSel), SELB[i] < 0 ? 32'h0 : 32'h1 << SELB[i]);
		end
	endtask
	initial begin
		scen_bases();
		scen_map();
		results();
	end
	// A hung handshake must still end in the one report.
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		results();
	end
endmodule
